// file: hda_pkg.sv
package hda_pkg;
  // ---------------------------------------------------------------
  // datagram layout
  // ---------------------------------------------------------------
  localparam int          DG_W        = 32;
  localparam int          MEM_SEL_BIT = 31;
  localparam int          ADDR_HI     = 30;
  localparam int          ADDR_LO     = 25;
  localparam int          RW_BIT      = 24;
  localparam int          DATA_W      = 24;
  localparam int          HDR_BITS    = 8;
  // ---------------------------------------------------------------
  // register space
  // ---------------------------------------------------------------
  localparam logic [1:0]  GRP_COMMON  = 2'h3;
  localparam logic [3:0]  RO_INDEX    = 4'hE;
  localparam logic [5:0]  GLOBAL_ADDR = 6'h3F;
  localparam int          GLB_WIDTH   = 16;
  localparam int          PREDIV_LSB  = 8;
  localparam int          PREDIV_W    = 4;
  localparam logic [3:0]  PREDIV_RST  = 4'hF;
  localparam logic [23:0] GLB_RST     = 24'h000F00;
  // ---------------------------------------------------------------
  // on-chip ram
  // ---------------------------------------------------------------
  localparam int          RAM_WORDS   = 128;
  localparam int          WORD_W      = 6;
  localparam logic [5:0]  RAM_DFLT_X  = 6'h2A;
  // ---------------------------------------------------------------
  // axi4-lite register offsets and fields
  // ---------------------------------------------------------------
  localparam logic [7:0]  OFS_CTRL    = 8'h00;
  localparam logic [7:0]  OFS_STATUS  = 8'h04;
  localparam logic [7:0]  OFS_SBYTE   = 8'h08;
  localparam logic [7:0]  OFS_GLOBAL  = 8'h0C;
  localparam int          CTRL_SMODE  = 0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// file: hda_axil.sv
`timescale 1ns/1ps
module hda_axil (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             wr_en,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);
  logic aw_have_q;
  logic w_have_q;

  // ---------------------------------------------------------------
  // write path: address and data taken in either order
  // ---------------------------------------------------------------
  assign awready = !aw_have_q && !bvalid;
  assign wready  = !w_have_q && !bvalid;
  assign wr_en   = aw_have_q && w_have_q && !bvalid;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      wr_addr   <= 8'h00;
      wr_data   <= 32'h0000_0000;
      wr_strb   <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_q <= 1'b1;
        wr_addr   <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_q <= 1'b1;
        wr_data  <= wdata;
        wr_strb  <= wstrb;
      end
      if (wr_en) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_ok ? hda_pkg::RESP_OKAY : hda_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // read path: one cycle from address to data
  // ---------------------------------------------------------------
  assign arready = !rvalid;
  assign rd_addr = araddr;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_data;
      rresp  <= rd_ok ? hda_pkg::RESP_OKAY : hda_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// file: hda_serial.sv
`timescale 1ns/1ps
module hda_serial (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        sck_pin,
  input  wire logic        csn_pin,
  input  wire logic        sdi_pin,
  input  wire logic [7:0]  status_byte,
  input  wire logic [23:0] rd_data,
  output logic             hdr_valid,
  output logic [7:0]       hdr,
  output logic             dg_valid,
  output logic [31:0]      dg,
  output logic             sdo
);
  logic [2:0]  s1_q, s2_q, s3_q;
  logic [2:0]  lvl_q;
  logic [31:0] sh_q;
  logic [5:0]  rcnt_q, fcnt_q;
  logic [7:0]  st_q;
  logic [23:0] rd_q;
  logic        rise, fall, cs_fall, act;

  // ---------------------------------------------------------------
  // pin sampling: three stages, level moves when stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q  <= 3'b010;
      s2_q  <= 3'b010;
      s3_q  <= 3'b010;
      lvl_q <= 3'b010;
    end else begin
      s1_q <= {sdi_pin, csn_pin, sck_pin};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < 3; i++) begin
        if (s2_q[i] == s3_q[i]) lvl_q[i] <= s3_q[i];
      end
    end
  end
  assign act     = !lvl_q[1];
  assign rise    = act && s2_q[0] && s3_q[0] && !lvl_q[0];
  assign fall    = act && !s2_q[0] && !s3_q[0] && lvl_q[0];
  assign cs_fall = !s2_q[1] && !s3_q[1] && lvl_q[1];

  // ---------------------------------------------------------------
  // shift in, msb first; header decoded after eight bits
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_q      <= 32'h0000_0000;
      rcnt_q    <= 6'h00;
      hdr_valid <= 1'b0;
      dg_valid  <= 1'b0;
    end else begin
      hdr_valid <= 1'b0;
      dg_valid  <= 1'b0;
      if (cs_fall) begin
        rcnt_q <= 6'h00;
      end else if (rise && rcnt_q < 6'd32) begin
        sh_q   <= {sh_q[30:0], s3_q[2]};
        rcnt_q <= rcnt_q + 6'd1;
        hdr_valid <= (rcnt_q == 6'd7);
        dg_valid  <= (rcnt_q == 6'd31);
      end
    end
  end
  assign hdr = sh_q[7:0];
  assign dg  = sh_q;

  // ---------------------------------------------------------------
  // reply: status byte first, then read data of this same datagram
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q   <= 8'h00;
      rd_q   <= 24'h000000;
      fcnt_q <= 6'h00;
      sdo    <= 1'b0;
    end else begin
      if (cs_fall) begin
        st_q   <= status_byte;
        fcnt_q <= 6'h00;
      end else if (fall && fcnt_q < 6'd31) begin
        fcnt_q <= fcnt_q + 6'd1;
      end
      if (hdr_valid) rd_q <= rd_data;
      if (fcnt_q < 6'd8) sdo <= st_q[3'd7 - fcnt_q[2:0]];
      else sdo <= rd_q[5'd31 - fcnt_q[4:0]];
    end
  end
endmodule

// file: hda_top.sv
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module hda_top #(
  parameter int RAM_WORDS = hda_pkg::RAM_WORDS
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        SCK,
  input  wire logic        CS_N,
  input  wire logic        SDI,
  output logic             HOST_SERIAL_OUT,
  output logic             CHAIN_TX_EN,
  output logic [3:0]       RO_TRIGGER,
  output logic [3:0]       SERIAL_CLOCK_PREDIV,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);
  logic [1:0]  rst_sync_q;
  logic        rst_n;
  logic [23:0] reg_q [0:63];
  logic [5:0]  ram_q [0:RAM_WORDS-1];
  logic [7:0]  wcnt_q [0:3];
  logic        init_busy_q;
  logic [6:0]  init_idx_q;
  logic [31:0] ctrl_q;
  logic [7:0]  sbyte_q;
  logic [3:0]  trig_q;
  logic        hdr_valid, dg_valid, sdo;
  logic [7:0]  hdr;
  logic [31:0] dg;
  logic [23:0] ser_rd;
  logic        wr_en, wr_ok, rd_ok;
  logic [7:0]  wr_addr, rd_addr;
  logic [31:0] wr_data, ax_rd;
  logic [3:0]  wr_strb;
  logic        dg_mem, dg_wr, ro_hit;
  logic [5:0]  dg_addr;
  logic [6:0]  even_w;

  // ---------------------------------------------------------------
  // reset release through two flops
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // ---------------------------------------------------------------
  // shared helpers
  // ---------------------------------------------------------------
  // width mask per register
  function automatic logic [23:0] reg_mask(input logic [5:0] a);
    reg_mask = (a == hda_pkg::GLOBAL_ADDR) ? 24'h00FFFF : 24'hFFFFFF;
  endfunction
  function automatic logic is_ro(input logic [5:0] a);
    is_ro = (a[3:0] == hda_pkg::RO_INDEX);
  endfunction
  function automatic logic [5:0] ram_dflt(input logic [6:0] i);
    ram_dflt = i[5:0] ^ hda_pkg::RAM_DFLT_X;
  endfunction
  // read-back of registers and ram pairs
  function automatic logic [23:0] mem_read(input logic m, input logic [5:0] a);
    if (m) mem_read = {12'h000, ram_q[{a, 1'b1}], ram_q[{a, 1'b0}]};
    else if (is_ro(a)) mem_read = {16'h0000, wcnt_q[a[5:4]]};
    else mem_read = reg_q[a] & reg_mask(a);
  endfunction

  // ---------------------------------------------------------------
  // datagram field split
  // ---------------------------------------------------------------
  // space select and address
  assign dg_mem  = dg[hda_pkg::MEM_SEL_BIT];
  assign dg_addr = dg[hda_pkg::ADDR_HI:hda_pkg::ADDR_LO];
  assign dg_wr   = dg_valid && !dg[hda_pkg::RW_BIT];
  assign ro_hit  = dg_wr && !dg_mem && is_ro(dg_addr);
  assign even_w  = {dg_addr, 1'b0};
  // read data of the header just received; a process also wakes on stores
  always_comb begin
    ser_rd = mem_read(hdr[7], hdr[6:1]);
  end

  // serial port, 32 bits msb first
  hda_serial u_serial (
    .clk         (CLK),
    .rst_n       (rst_n),
    .sck_pin     (SCK),
    .csn_pin     (CS_N),
    .sdi_pin     (SDI),
    .status_byte (sbyte_q),
    .rd_data     (ser_rd),
    .hdr_valid   (hdr_valid),
    .hdr         (hdr),
    .dg_valid    (dg_valid),
    .dg          (dg),
    .sdo         (sdo)
  );

  // ---------------------------------------------------------------
  // register set writes
  // ---------------------------------------------------------------
  // one write, one register
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 64; i++) begin
        reg_q[i] <= (i == 63) ? hda_pkg::GLB_RST : 24'h000000;
      end
    end else if (dg_wr && !dg_mem && !is_ro(dg_addr)) begin
      reg_q[dg_addr] <= dg[23:0] & reg_mask(dg_addr);
    end
  end

  // ---------------------------------------------------------------
  // read-only addresses: per-group write counter and trigger pulse
  // ---------------------------------------------------------------
  // write to read-only index fires a trigger
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      trig_q <= 4'h0;
      for (int g = 0; g < 4; g++) wcnt_q[g] <= 8'h00;
    end else begin
      trig_q <= 4'h0;
      if (ro_hit) trig_q[dg_addr[5:4]] <= 1'b1;
      if (dg_wr && !dg_mem && !is_ro(dg_addr)) begin
        wcnt_q[dg_addr[5:4]] <= wcnt_q[dg_addr[5:4]] + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // ram: power-up preload, then paired writes
  // ---------------------------------------------------------------
  // preload walks one word per clock; host ram writes are dropped meanwhile
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      init_busy_q <= 1'b1;
      init_idx_q  <= 7'h00;
      for (int i = 0; i < RAM_WORDS; i++) ram_q[i] <= 6'h00;
    end else if (init_busy_q) begin
      ram_q[init_idx_q] <= ram_dflt(init_idx_q);
      init_idx_q        <= init_idx_q + 7'h01;
      if (init_idx_q == 7'(RAM_WORDS - 1)) init_busy_q <= 1'b0;
    end else if (dg_wr && dg_mem) begin
      // even word low bits, odd word next
      ram_q[even_w]         <= dg[5:0];
      ram_q[even_w | 7'h01] <= dg[11:6];
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite control registers
  // ---------------------------------------------------------------
  assign wr_ok = (wr_addr == hda_pkg::OFS_CTRL) || (wr_addr == hda_pkg::OFS_SBYTE);
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= 32'h0000_0000;
      sbyte_q <= 8'h00;
    end else if (wr_en) begin
      if (wr_addr == hda_pkg::OFS_CTRL && wr_strb[0]) begin
        ctrl_q[0] <= wr_data[hda_pkg::CTRL_SMODE];
      end else if (wr_addr == hda_pkg::OFS_SBYTE && wr_strb[0]) begin
        sbyte_q <= wr_data[7:0];
      end
    end
  end

  // read decode
  always_comb begin
    rd_ok = 1'b1;
    if (rd_addr == hda_pkg::OFS_CTRL) begin
      ax_rd = ctrl_q;
    end else if (rd_addr == hda_pkg::OFS_STATUS) begin
      ax_rd = {16'h0000, trig_q, 3'h0, init_busy_q, 1'b0, init_idx_q};
    end else if (rd_addr == hda_pkg::OFS_SBYTE) begin
      ax_rd = {24'h000000, sbyte_q};
    end else if (rd_addr == hda_pkg::OFS_GLOBAL) begin
      ax_rd = {8'h00, reg_q[hda_pkg::GLOBAL_ADDR]};
    end else begin
      ax_rd = 32'h0000_0000;
      rd_ok = 1'b0;
    end
  end

  hda_axil u_axil (
    .clk     (CLK),
    .rst_n   (rst_n),
    .awaddr  (S_AXI_AWADDR),
    .awvalid (S_AXI_AWVALID),
    .awready (S_AXI_AWREADY),
    .wdata   (S_AXI_WDATA),
    .wstrb   (S_AXI_WSTRB),
    .wvalid  (S_AXI_WVALID),
    .wready  (S_AXI_WREADY),
    .bresp   (S_AXI_BRESP),
    .bvalid  (S_AXI_BVALID),
    .bready  (S_AXI_BREADY),
    .araddr  (S_AXI_ARADDR),
    .arvalid (S_AXI_ARVALID),
    .arready (S_AXI_ARREADY),
    .rdata   (S_AXI_RDATA),
    .rresp   (S_AXI_RRESP),
    .rvalid  (S_AXI_RVALID),
    .rready  (S_AXI_RREADY),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (ax_rd),
    .rd_ok   (rd_ok)
  );

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      HOST_SERIAL_OUT     <= 1'b0;
      CHAIN_TX_EN         <= 1'b0;
      RO_TRIGGER          <= 4'h0;
      SERIAL_CLOCK_PREDIV <= hda_pkg::PREDIV_RST;
    end else begin
      HOST_SERIAL_OUT     <= sdo;
      // chain held quiet until preload is done
      CHAIN_TX_EN         <= ctrl_q[0] && !init_busy_q;
      RO_TRIGGER          <= trig_q;
      SERIAL_CLOCK_PREDIV <= reg_q[hda_pkg::GLOBAL_ADDR][hda_pkg::PREDIV_LSB +: hda_pkg::PREDIV_W];
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!rst_n);

  a_chain_quiet_init: assert property (init_busy_q |=> !CHAIN_TX_EN)
    else $error("chain enabled during preload");
  a_preload_len: assert property ($fell(init_busy_q) |-> $past(init_idx_q) == 7'h7F)
    else $error("preload length wrong");
  a_ram_even_word: assert property (dg_wr && dg_mem && !init_busy_q |=> ram_q[$past(even_w)] == $past(dg[5:0]))
    else $error("even ram word not stored");
  a_ram_odd_word: assert property (dg_wr && dg_mem && !init_busy_q |=> ram_q[$past(even_w) | 7'h01] == $past(dg[11:6]))
    else $error("odd ram word not stored");
  a_ro_trigger: assert property (ro_hit |=> ##1 RO_TRIGGER != 4'h0)
    else $error("read-only write gave no trigger");
  a_ro_no_store: assert property (ro_hit |=> reg_q[$past(dg_addr)] == $past(reg_q[dg_addr]))
    else $error("read-only address stored data");
  a_global_width: assert property (reg_q[hda_pkg::GLOBAL_ADDR][23:16] == 8'h00)
    else $error("global register upper bits set");
  a_reg_write: assert property (dg_wr && !dg_mem && !is_ro(dg_addr)
                                |=> reg_q[$past(dg_addr)] == ($past(dg[23:0]) & reg_mask($past(dg_addr))))
    else $error("register write lost");
  a_prediv_follow: assert property (dg_wr && !dg_mem && dg_addr == hda_pkg::GLOBAL_ADDR
                                    |=> ##1 SERIAL_CLOCK_PREDIV == $past(dg[11:8], 2))
    else $error("prediv not updated");
  a_trig_pulse: assert property (RO_TRIGGER != 4'h0 |=> RO_TRIGGER == 4'h0 || $past(ro_hit, 2))
    else $error("trigger longer than a pulse");

  c_ram_write: cover property (dg_wr && dg_mem && !init_busy_q);
  c_reg_read: cover property (dg_valid && dg[hda_pkg::RW_BIT] && !dg_mem);
  c_ro_write: cover property (ro_hit);
  c_preload_done: cover property ($fell(init_busy_q));
endmodule

// file: hda_host.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// host serial master model
// ------------------------------------------------------------
module hda_host (
  input  wire logic clk,
  output logic      sck,
  output logic      cs_n,
  output logic      sdi,
  input  wire logic sdo
);
  // deselected link with a still serial clock
  initial begin
    sck  = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end
  // packed fields in one datagram
  // phases of 4 to 8 clocks keep the 3-clock minimums with margin;
  // the reply bit reaches the pin six clocks after a fall, so low lasts 8
  task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 31; i >= 0; i--) begin
      sdi <= tx[i];
      repeat (8) @(posedge clk);
      rx[i] = sdo;   // reply bit taken at the clock rise
      sck   <= 1'b1;
      repeat (4) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    // released data line must not look like a held bit
    sdi  <= ~sdi;
    repeat (8) @(posedge clk);
  endtask
endmodule

// file: hda_top_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end
module hda_top_tb;
  logic        CLK, NRST, SCK, CS_N, SDI, HOST_SERIAL_OUT, CHAIN_TX_EN;
  logic [3:0]  RO_TRIGGER, SERIAL_CLOCK_PREDIV, S_AXI_WSTRB, ro_seen, m;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rx, d;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic        S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [5:0]  ra [5];
  logic [23:0] dv [5];
  int          err_total, checked;
  // ------------------------------------------------------------
  // clock, design, host model
  // ------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  hda_top u_dut (.CLK(CLK), .NRST(NRST), .SCK(SCK), .CS_N(CS_N), .SDI(SDI), .HOST_SERIAL_OUT(HOST_SERIAL_OUT),
    .CHAIN_TX_EN(CHAIN_TX_EN), .RO_TRIGGER(RO_TRIGGER), .SERIAL_CLOCK_PREDIV(SERIAL_CLOCK_PREDIV),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));
  hda_host u_host (.clk(CLK), .sck(SCK), .cs_n(CS_N), .sdi(SDI), .sdo(HOST_SERIAL_OUT));
  // one-cycle trigger pulses are collected so none is missed
  always @(posedge CLK) ro_seen <= (NRST ? ro_seen : 4'h0) | RO_TRIGGER;
  // ------------------------------------------------------------
  // access tasks
  // ------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done  = 1'b0;
    S_AXI_AWADDR  <= a;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WDATA   <= v;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_BREADY  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge CLK);
      if (S_AXI_AWREADY && !aw_done) begin
        aw_done = 1'b1;
        S_AXI_AWVALID <= 1'b0;
      end
      if (S_AXI_WREADY && !w_done) begin
        w_done = 1'b1;
        S_AXI_WVALID <= 1'b0;
      end
    end
    do @(posedge CLK); while (!S_AXI_BVALID);
    rs = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    // one edge apart, so a following call never re-raises ready in this step
    @(posedge CLK);
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY  <= 1'b1;
    do @(posedge CLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    do @(posedge CLK); while (!S_AXI_RVALID);
    v  = S_AXI_RDATA;
    rs = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    @(posedge CLK);
  endtask
  // space bit, six address bits, read bit, 24 data bits
  task automatic ser(input logic sp, input logic [5:0] a, input logic rd, input logic [23:0] v);
    u_host.xfer({sp, a, rd, v}, rx);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge CLK);
    err_total++;
    $display("unexpected at %0t: timeout", $time);
    stop_test();
  end
  initial begin
    {NRST, S_AXI_AWADDR, S_AXI_AWVALID, S_AXI_WDATA, S_AXI_WVALID, S_AXI_BREADY} = '0;
    {S_AXI_ARADDR, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    S_AXI_WSTRB = 4'hF;
    ra = '{6'h0D, 6'h1D, 6'h2D, 6'h30, 6'h3D};
    dv = '{24'h000123, 24'hABCDEF, 24'h800001, 24'h5A5A5A, 24'hFFFFFF};
    repeat (20) @(posedge CLK);
    NRST <= 1'b1;
    repeat (3) @(posedge CLK);
    `CHK(SERIAL_CLOCK_PREDIV, 4'hF)
    axi_wr(hda_pkg::OFS_CTRL, 32'h00000001, r);
    axi_rd(hda_pkg::OFS_STATUS, d, r);
    `CHK(d[8], 1'b1)
    `CHK(CHAIN_TX_EN, 1'b0)
    repeat (130) @(posedge CLK);
    `CHK(CHAIN_TX_EN, 1'b1)
    axi_rd(hda_pkg::OFS_GLOBAL, d, r);
    `CHK(d, 32'h00000F00)
    axi_rd(8'h40, d, r);
    `CHK(r, hda_pkg::RESP_SLVERR)
    axi_wr(hda_pkg::OFS_GLOBAL, 32'h0, r);
    `CHK(r, hda_pkg::RESP_SLVERR)
    axi_wr(hda_pkg::OFS_SBYTE, 32'h00000095, r);
    ser(1'b1, 6'h00, 1'b1, 24'h0);
    `CHK(rx, 32'h95000AEA)
    for (int k = 0; k < 5; k++) begin
      ser(1'b0, ra[k], 1'b0, dv[k]);
      ser(1'b0, ra[k], 1'b1, 24'h0);
      `CHK(rx[23:0], dv[k])
    end
    ser(1'b0, ra[0], 1'b1, 24'h0);
    `CHK(rx[23:0], dv[0])
    ser(1'b0, 6'h3F, 1'b0, 24'hFF0A00);
    `CHK(SERIAL_CLOCK_PREDIV, 4'hA)
    ser(1'b0, 6'h3F, 1'b1, 24'h0);
    `CHK(rx[23:0], 24'h000A00)
    ser(1'b1, 6'h10, 1'b0, 24'hF00555);
    ser(1'b1, 6'h10, 1'b1, 24'h0);
    `CHK(rx[23:0], 24'h000555)
    ser(1'b1, 6'h3F, 1'b0, 24'h0008E1);
    ser(1'b1, 6'h3F, 1'b1, 24'h0);
    `CHK(rx[23:0], 24'h0008E1)
    axi_rd(hda_pkg::OFS_GLOBAL, d, r);
    `CHK(d, 32'h00000A00)
    m = 4'h0;
    for (int g = 0; g < 4; g++) begin
      m[g] = 1'b1;
      ser(1'b0, {2'(g), 4'hE}, 1'b0, 24'h00BEEF);
      `CHK(ro_seen, m)
      ser(1'b0, {2'(g), 4'hE}, 1'b1, 24'h0);
      // group 3 has taken three register writes (30, 3D, 3F), the others one
      `CHK(rx[23:0], (g < 3) ? 24'h000001 : 24'h000003)
    end
    stop_test();
  end
endmodule
